// ==== rtl/gpp_cfg.svh ====
// constants for the general purpose pin port
`ifndef GPP_CFG_SVH
`define GPP_CFG_SVH

`define GPP_PINS          8
`define GPP_AW            12
// data window: addr[11:10] zero, addr[9:2] is the pin mask
`define GPP_DATA_REGION   2'h0
`define GPP_OFS_DIR       12'h400
`define GPP_OFS_TRIG      12'h404
`define GPP_OFS_STRENGTH  12'h408
`define GPP_OFS_SLEW      12'h40C
`define GPP_OFS_PULL      12'h410
`define GPP_OFS_ODRAIN    12'h414
`define GPP_OFS_PSEL      12'h418
`define GPP_OFS_IMASK     12'h41C
`define GPP_OFS_RAW       12'h420
`define GPP_OFS_MASKED    12'h424
`define GPP_OFS_ICLR      12'h428

`define GPP_RST_DIR       16'h0000
`define GPP_RST_TRIG      24'h000000
`define GPP_RST_STRENGTH  16'h0000
`define GPP_RST_SLEW      8'h00
`define GPP_RST_PULL_OFF  16'h0000
`define GPP_RST_PULL_UP   16'h5555
`define GPP_RST_ODRAIN    8'h00
`define GPP_RST_PSEL      8'h00
`define GPP_RST_IMASK     8'h00

`endif

// ==== rtl/gpp_pkg.sv ====
// types of the general purpose pin port
package gpp_pkg;
   typedef enum logic [1:0] {
      GPP_DIR_IN  = 2'h0,
      GPP_DIR_OUT = 2'h1,
      GPP_DIR_HW  = 2'h2
   } gpp_dir_t;

   typedef enum logic [2:0] {
      GPP_TRIG_FALL = 3'h0,
      GPP_TRIG_RISE = 3'h1,
      GPP_TRIG_BOTH = 3'h2,
      GPP_TRIG_LOW  = 3'h3,
      GPP_TRIG_HIGH = 3'h4
   } gpp_trig_t;

   typedef enum logic [1:0] {
      GPP_STR_2MA = 2'h0,
      GPP_STR_4MA = 2'h1,
      GPP_STR_8MA = 2'h2
   } gpp_str_t;

   typedef enum logic [1:0] {
      GPP_PULL_OFF  = 2'h0,
      GPP_PULL_UP   = 2'h1,
      GPP_PULL_DOWN = 2'h2
   } gpp_pull_t;
endpackage

// ==== rtl/gpp_in_sync.sv ====
// one pin input synchroniser and trigger detector
`timescale 1ns/1ps
module gpp_in_sync (
   // clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       rstn_in,
   // pin and trigger kind
   input  wire logic       pad_in,
   input  wire logic [2:0] trig_in,
   // results
   output logic            sync_out,
   output logic            event_out
);
   logic meta;
   logic prev;
   logic next_meta;
   logic next_sync;
   logic next_prev;

   always_comb begin
      next_meta = pad_in;
      next_sync = meta;
      next_prev = sync_out;
      event_out = 1'b0;
      case (trig_in)
         gpp_pkg::GPP_TRIG_FALL: event_out = prev & ~sync_out;
         gpp_pkg::GPP_TRIG_RISE: event_out = ~prev & sync_out;
         gpp_pkg::GPP_TRIG_BOTH: event_out = prev ^ sync_out;
         gpp_pkg::GPP_TRIG_LOW:  event_out = ~sync_out;
         gpp_pkg::GPP_TRIG_HIGH: event_out = sync_out;
         default:                event_out = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         meta     <= 1'b0;
         sync_out <= 1'b0;
         prev     <= 1'b0;
      end else begin
         meta     <= next_meta;
         sync_out <= next_sync;
         prev     <= next_prev;
      end
   end
endmodule

// ==== rtl/gpp_out_drive.sv ====
// one pin output driver and pad control
`timescale 1ns/1ps
module gpp_out_drive (
   // clock and reset
   input  wire logic       core_clk_in,
   input  wire logic       rstn_in,
   // configuration
   input  wire logic [1:0] dir_in,
   input  wire logic       psel_in,
   input  wire logic       present_in,
   input  wire logic       odrain_in,
   input  wire logic [1:0] strength_in,
   input  wire logic       slew_in,
   input  wire logic [1:0] pull_in,
   // data sources
   input  wire logic       sw_val_in,
   input  wire logic       periph_val_in,
   input  wire logic       periph_oe_in,
   // pad side
   output logic            pin_out,
   output logic            pin_oe_out,
   output logic [1:0]      strength_out,
   output logic            slew_out,
   output logic            pull_up_out,
   output logic            pull_down_out
);
   logic       hw;
   logic       val;
   logic       en;
   logic       next_pin;
   logic       next_oe;
   logic [1:0] next_str;
   logic       next_slew;
   logic       next_pu;
   logic       next_pd;

   always_comb begin
      hw  = psel_in | (dir_in == gpp_pkg::GPP_DIR_HW);
      val = 1'b0;
      en  = 1'b0;
      if (hw) begin
         // no peripheral behind this pin: stay quiet
         val = present_in & periph_val_in;
         en  = present_in & periph_oe_in;
      end else if (dir_in == gpp_pkg::GPP_DIR_OUT) begin
         val = sw_val_in;
         en  = 1'b1;
      end
      if (odrain_in) begin
         // only ever pulls low, line floats for a one
         next_pin = 1'b0;
         next_oe  = en & ~val;
      end else begin
         next_pin = val;
         next_oe  = en;
      end
      next_str  = strength_in;
      next_slew = slew_in & (strength_in == gpp_pkg::GPP_STR_8MA);
      next_pu   = (pull_in == gpp_pkg::GPP_PULL_UP);
      next_pd   = (pull_in == gpp_pkg::GPP_PULL_DOWN);
   end

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pin_out       <= 1'b0;
         pin_oe_out    <= 1'b0;
         strength_out  <= 2'h0;
         slew_out      <= 1'b0;
         pull_up_out   <= 1'b0;
         pull_down_out <= 1'b0;
      end else begin
         pin_out       <= next_pin;
         pin_oe_out    <= next_oe;
         strength_out  <= next_str;
         slew_out      <= next_slew;
         pull_up_out   <= next_pu;
         pull_down_out <= next_pd;
      end
   end
endmodule

// ==== rtl/gpp_port.sv ====
// general purpose pin port top: registers, pins, interrupt
`timescale 1ns/1ps
`include "gpp_cfg.svh"
module gpp_port #(
   parameter logic       PULL_UP_RESET  = 1'b0,
   parameter logic [7:0] PERIPH_PRESENT = 8'hFF
) (
   // clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        rstn_in,
   // register bus
   input  wire logic [11:0] addr_in,
   input  wire logic [31:0] wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic [31:0]      rdata_out,
   // pins
   input  wire logic [7:0]  pin_in,
   output logic [7:0]       pin_out,
   output logic [7:0]       pin_oe_out,
   // pad controls
   output logic [15:0]      pad_strength_out,
   output logic [7:0]       pad_slew_out,
   output logic [7:0]       pad_pull_up_out,
   output logic [7:0]       pad_pull_down_out,
   // peripheral functions
   input  wire logic [7:0]  periph_val_in,
   input  wire logic [7:0]  periph_oe_in,
   output logic [7:0]       periph_val_out,
   // interrupt request
   output logic             irq_out
);
   localparam logic [15:0] PULL_RST =
      PULL_UP_RESET ? `GPP_RST_PULL_UP : `GPP_RST_PULL_OFF;

   // configuration and state
   logic [15:0] dir;
   logic [23:0] trig;
   logic [15:0] strength;
   logic [7:0]  slew;
   logic [15:0] pull;
   logic [7:0]  odrain;
   logic [7:0]  psel;
   logic [7:0]  imask;
   logic [7:0]  raw;
   logic [7:0]  outv;
   logic [7:0]  pin_sync;
   logic [7:0]  pin_event;
   logic [7:0]  hw_own;

   // next values
   logic [15:0] next_dir;
   logic [23:0] next_trig;
   logic [15:0] next_strength;
   logic [7:0]  next_slew;
   logic [15:0] next_pull;
   logic [7:0]  next_odrain;
   logic [7:0]  next_psel;
   logic [7:0]  next_imask;
   logic [7:0]  next_raw;
   logic [7:0]  next_outv;
   logic [31:0] next_rdata;
   logic        next_irq;
   logic [7:0]  next_periph;

   // decode helpers
   logic        in_data;
   logic [7:0]  amask;
   logic [7:0]  clr;

   genvar n;
   generate
      for (n = 0; n < `GPP_PINS; n = n + 1) begin : g_pin
         assign hw_own[n] = psel[n] |
            (dir[2*n+1:2*n] == gpp_pkg::GPP_DIR_HW);

         gpp_in_sync u_in (
            .core_clk_in (core_clk_in),
            .rstn_in     (rstn_in),
            .pad_in      (pin_in[n]),
            .trig_in     (trig[3*n+2:3*n]),
            .sync_out    (pin_sync[n]),
            .event_out   (pin_event[n])
         );

         gpp_out_drive u_out (
            .core_clk_in   (core_clk_in),
            .rstn_in       (rstn_in),
            .dir_in        (dir[2*n+1:2*n]),
            .psel_in       (psel[n]),
            .present_in    (PERIPH_PRESENT[n]),
            .odrain_in     (odrain[n]),
            .strength_in   (strength[2*n+1:2*n]),
            .slew_in       (slew[n]),
            .pull_in       (pull[2*n+1:2*n]),
            .sw_val_in     (outv[n]),
            .periph_val_in (periph_val_in[n]),
            .periph_oe_in  (periph_oe_in[n]),
            .pin_out       (pin_out[n]),
            .pin_oe_out    (pin_oe_out[n]),
            .strength_out  (pad_strength_out[2*n+1:2*n]),
            .slew_out      (pad_slew_out[n]),
            .pull_up_out   (pad_pull_up_out[n]),
            .pull_down_out (pad_pull_down_out[n])
         );
      end
   endgenerate

   always_comb begin
      in_data = (addr_in[11:10] == `GPP_DATA_REGION);
      amask   = addr_in[9:2];

      next_dir      = dir;
      next_trig     = trig;
      next_strength = strength;
      next_slew     = slew;
      next_pull     = pull;
      next_odrain   = odrain;
      next_psel     = psel;
      next_imask    = imask;
      next_outv     = outv;
      clr           = 8'h00;

      if (wr_in) begin
         if (in_data) begin
            // one write moves every selected pin at once
            next_outv = (outv & ~amask) | (wdata_in[7:0] & amask);
         end else begin
            case (addr_in)
               `GPP_OFS_DIR:      next_dir      = wdata_in[15:0];
               `GPP_OFS_TRIG:     next_trig     = wdata_in[23:0];
               `GPP_OFS_STRENGTH: next_strength = wdata_in[15:0];
               `GPP_OFS_SLEW:     next_slew     = wdata_in[7:0];
               `GPP_OFS_PULL:     next_pull     = wdata_in[15:0];
               `GPP_OFS_ODRAIN:   next_odrain   = wdata_in[7:0];
               `GPP_OFS_PSEL:     next_psel     = wdata_in[7:0];
               `GPP_OFS_IMASK:    next_imask    = wdata_in[7:0];
               `GPP_OFS_ICLR:     clr           = wdata_in[7:0];
               default:           clr           = 8'h00;
            endcase
         end
      end

      // a new event in the clearing cycle survives; level trigger
      // re-sets while the level persists, so clear only sticks once gone
      next_raw = (raw & ~clr) | pin_event;

      next_irq = |(raw & imask);

      next_rdata = 32'h0000_0000;
      if (rd_in) begin
         if (in_data) begin
            next_rdata = {24'h00_0000, pin_sync & amask};
         end else begin
            case (addr_in)
               `GPP_OFS_DIR:      next_rdata = {16'h0000, dir};
               `GPP_OFS_TRIG:     next_rdata = {8'h00, trig};
               `GPP_OFS_STRENGTH: next_rdata = {16'h0000, strength};
               `GPP_OFS_SLEW:     next_rdata = {24'h00_0000, slew};
               `GPP_OFS_PULL:     next_rdata = {16'h0000, pull};
               `GPP_OFS_ODRAIN:   next_rdata = {24'h00_0000, odrain};
               `GPP_OFS_PSEL:     next_rdata = {24'h00_0000, psel};
               `GPP_OFS_IMASK:    next_rdata = {24'h00_0000, imask};
               `GPP_OFS_RAW:      next_rdata = {24'h00_0000, raw};
               `GPP_OFS_MASKED:   next_rdata = {24'h00_0000, raw & imask};
               default:           next_rdata = 32'h0000_0000;
            endcase
         end
      end

      // peripheral sees the pin only when it owns it and exists
      next_periph = pin_sync & hw_own & PERIPH_PRESENT;
   end

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         dir            <= `GPP_RST_DIR;
         trig           <= `GPP_RST_TRIG;
         strength       <= `GPP_RST_STRENGTH;
         slew           <= `GPP_RST_SLEW;
         pull           <= PULL_RST;
         odrain         <= `GPP_RST_ODRAIN;
         psel           <= `GPP_RST_PSEL;
         imask          <= `GPP_RST_IMASK;
         raw            <= 8'h00;
         outv           <= 8'h00;
         rdata_out      <= 32'h0000_0000;
         irq_out        <= 1'b0;
         periph_val_out <= 8'h00;
      end else begin
         dir            <= next_dir;
         trig           <= next_trig;
         strength       <= next_strength;
         slew           <= next_slew;
         pull           <= next_pull;
         odrain         <= next_odrain;
         psel           <= next_psel;
         imask          <= next_imask;
         raw            <= next_raw;
         outv           <= next_outv;
         rdata_out      <= next_rdata;
         irq_out        <= next_irq;
         periph_val_out <= next_periph;
      end
   end
endmodule

// ==== rtl/dummy_none.sv ====
// spare slot: holds no logic, per-pin logic sits in gpp_in_sync and gpp_out_drive

// ==== testbench/gpp_port_props.sv ====
// assertion checker for the pin port top
`timescale 1ns/1ps
`include "gpp_cfg.svh"
module gpp_port_props (
   // clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        rstn_in,
   // register bus
   input  wire logic [11:0] addr_in,
   input  wire logic        rd_in,
   input  wire logic [31:0] rdata_out,
   // pads and interrupt
   input  wire logic [7:0]  pin_oe_out,
   input  wire logic [15:0] pad_strength_out,
   input  wire logic [7:0]  pad_slew_out,
   input  wire logic [7:0]  pad_pull_up_out,
   input  wire logic [7:0]  pad_pull_down_out,
   input  wire logic        irq_out
);
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!rstn_in);
   logic [7:0] at8;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         at8[i] = pad_strength_out[2*i+:2] == 2'h2;
      end
   end
   sequence s_rd_data;
      rd_in && addr_in[11:10] == `GPP_DATA_REGION;
   endsequence
   sequence s_rd_masked;
      rd_in && addr_in == `GPP_OFS_MASKED;
   endsequence
   chk_rd_idle: assert property (!rd_in |=> rdata_out == 32'h0)
      else $error("read data not zero outside answer cycle");
   chk_rd_mask: assert property (s_rd_data |=>
      (rdata_out[7:0] & ~$past(addr_in[9:2])) == 8'h0)
      else $error("unselected pin returned nonzero");
   chk_rd_upper: assert property (s_rd_data |=>
      rdata_out[31:8] == 24'h0)
      else $error("data read upper bits not zero");
   chk_irq_or: assert property (s_rd_masked |=>
      irq_out == (rdata_out[7:0] != 8'h0))
      else $error("irq differs from masked status");
   chk_unmapped: assert property (rd_in && addr_in > `GPP_OFS_ICLR |=>
      rdata_out == 32'h0)
      else $error("unmapped read not zero");
   chk_slew_8ma: assert property ((pad_slew_out & ~at8) == 8'h0)
      else $error("slew limit without 8 mA");
   chk_pull_excl: assert property (
      (pad_pull_up_out & pad_pull_down_out) == 8'h0)
      else $error("pull up and down together");
   chk_reset_in: assert property ($rose(rstn_in) |->
      pin_oe_out == 8'h0 && pad_strength_out == 16'h0)
      else $error("pad state wrong after reset");
endmodule

bind gpp_port gpp_port_props i_props (
   .core_clk_in, .rstn_in, .addr_in, .rd_in, .rdata_out, .pin_oe_out,
   .pad_strength_out, .pad_slew_out, .pad_pull_up_out,
   .pad_pull_down_out, .irq_out
);

// ==== testbench/gpp_pin_world.sv ====
// pad wires and outside drivers of the eight pins
`timescale 1ns/1ps
module gpp_pin_world (
   // clock
   input  wire logic       core_clk_in,
   // port pad side
   input  wire logic [7:0] pad_val_in,
   input  wire logic [7:0] pad_oe_in,
   input  wire logic [7:0] pull_up_in,
   input  wire logic [7:0] pull_dn_in,
   // outside drivers
   input  wire logic [7:0] ext_en_in,
   input  wire logic [7:0] ext_val_in,
   // resolved level
   output logic [7:0]      level_out
);
   logic [7:0] flt = 8'h5A;
   // a floating pad wanders, so nothing may lean on it
   always @(posedge core_clk_in) begin
      flt <= ~flt;
   end
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (pad_oe_in[i]) begin
            level_out[i] = pad_val_in[i];
         end else if (ext_en_in[i]) begin
            level_out[i] = ext_val_in[i];
         end else if (pull_up_in[i] | pull_dn_in[i]) begin
            level_out[i] = pull_up_in[i];
         end else begin
            level_out[i] = flt[i];
         end
      end
   end
endmodule

// ==== testbench/gpp_port_bench.sv ====
// self-checking bench for the pin port
`timescale 1ns/1ps
`include "gpp_cfg.svh"
module gpp_port_bench;
   logic        core_clk_in, rstn_in, wr_in, rd_in, irq_out, rd_seen;
   logic [11:0] addr_in;
   logic [31:0] wdata_in, rdata_out;
   logic [15:0] pad_strength_out, rnd;
   logic [7:0]  pin_in, pin_out, pin_oe_out, pad_slew_out, ov;
   logic [7:0]  pad_pull_up_out, pad_pull_down_out, ext_en, ext_val;
   logic [7:0]  periph_val_in, periph_oe_in, periph_val_out;
   logic [7:0]  pu_alt;
   logic [31:0] exp_q[$], msk_q[$];
   logic [31:0] w[8] = '{32'hFFFF, 32'hFFFFFF, 32'hFFFF, 32'hFF,
                         32'hFFFF, 32'hFF, 32'hFF, 32'hFF};
   // last entry: trigger code 5 must never latch anything
   logic [3:0]  ie[6] = '{4'h2, 4'h8, 4'hA, 4'hB, 4'hE, 4'h0};
   int          fail_count, samples_checked, cycles;

   gpp_port #(.PULL_UP_RESET(1'b0), .PERIPH_PRESENT(8'h7F)) i_dut (
      .core_clk_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in,
      .rdata_out, .pin_in, .pin_out, .pin_oe_out, .pad_strength_out,
      .pad_slew_out, .pad_pull_up_out, .pad_pull_down_out,
      .periph_val_in, .periph_oe_in, .periph_val_out, .irq_out);
   gpp_pin_world i_world (
      .core_clk_in, .pad_val_in(pin_out), .pad_oe_in(pin_oe_out),
      .pull_up_in(pad_pull_up_out), .pull_dn_in(pad_pull_down_out),
      .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pin_in));
   // second build with the pull-up reset default, only its pull-ups watched
   gpp_port #(.PULL_UP_RESET(1'b1), .PERIPH_PRESENT(8'h7F)) i_dut_pu (
      .core_clk_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in,
      .rdata_out(), .pin_in, .pin_out(), .pin_oe_out(),
      .pad_strength_out(), .pad_slew_out(), .pad_pull_up_out(pu_alt),
      .pad_pull_down_out(), .periph_val_in, .periph_oe_in,
      .periph_val_out(), .irq_out());

   initial begin
      core_clk_in = 1'b0;
      forever #50 core_clk_in = ~core_clk_in;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge core_clk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e,
                     input logic [31:0] m);
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      @(posedge core_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge core_clk_in);
      rd_in <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // answers are checked half a cycle after they are registered
   always @(posedge core_clk_in) begin
      rd_seen <= rd_in;
      cycles++;
      if (cycles == 6000) begin
         fail_count++;
         wrap_up();
      end
   end
   always @(negedge core_clk_in) begin
      if (rd_seen) begin
         chk(rdata_out & msk_q.pop_front(), exp_q.pop_front());
      end
   end

   initial begin
      rstn_in = 1'b0;
      addr_in = 12'h0;
      wdata_in = 32'h0;
      wr_in = 1'b0;
      rd_in = 1'b0;
      rd_seen = 1'b0;
      periph_val_in = 8'h0;
      periph_oe_in = 8'h0;
      ext_en = 8'h01;
      ext_val = 8'h0;
      rnd = 16'h9C65;
      fail_count = 0;
      samples_checked = 0;
      cycles = 0;
      repeat (5) @(posedge core_clk_in);
      rstn_in <= 1'b1;
      settle(1);
      chk({pin_oe_out, pad_slew_out, pad_strength_out}, 32'h0);
      chk({16'h0, pad_pull_up_out, pad_pull_down_out}, 32'h0);
      chk({24'h0, pu_alt}, 32'h000000FF);
      for (logic [11:0] a = 12'h400; a <= 12'h41C; a += 12'h4) begin
         rd(a, 32'h0, 32'hFFFFFFFF);
      end
      rd(`GPP_OFS_MASKED, 32'h0, 32'hFFFFFFFF);
      rd(12'h42C, 32'h0, 32'hFFFFFFFF);
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         wr(12'h400 + 12'(4 * i), {rnd[7:0], rnd} & w[i]);
         rd(12'h400 + 12'(4 * i), {rnd[7:0], rnd} & w[i], 32'hFFFFFFFF);
      end
      $display("readback test done");
      ext_en <= 8'h0;
      wr(`GPP_OFS_PSEL, 32'h0);
      wr(`GPP_OFS_ODRAIN, 32'h0);
      wr(`GPP_OFS_PULL, 32'h0);
      wr(`GPP_OFS_DIR, 32'h5555);
      wr(12'h3FC, 32'h0);
      wr(12'h024, 32'hFF);
      settle(4);
      chk({16'h0, pin_oe_out, pin_out}, 32'hFF09);
      ov = 8'h09;
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         wr({2'h0, rnd[7:0], 2'h0}, {24'h0, rnd[15:8]});
         ov = (ov & ~rnd[7:0]) | (rnd[15:8] & rnd[7:0]);
         settle(4);
         chk({24'h0, pin_out}, {24'h0, ov});
         rd({2'h0, rnd[15:8], 2'h0}, {24'h0, ov & rnd[15:8]}, 32'hFF);
      end
      $display("data test done");
      wr(`GPP_OFS_STRENGTH, 32'h0026);
      wr(`GPP_OFS_SLEW, 32'h03);
      wr(`GPP_OFS_PULL, 32'h0069);
      settle(2);
      chk({pad_slew_out, pad_pull_up_out, pad_strength_out}, 32'h01090026);
      chk({24'h0, pad_pull_down_out}, 32'h06);
      wr(`GPP_OFS_DIR, 32'h0);
      settle(6);
      rd(12'h03C, 32'h09, 32'hFF);
      wr(`GPP_OFS_DIR, 32'h0001);
      wr(`GPP_OFS_ODRAIN, 32'h01);
      wr(12'h004, 32'h0);
      settle(3);
      chk({30'h0, pin_oe_out[0], pin_out[0]}, 32'h2);
      wr(12'h004, 32'h1);
      settle(3);
      chk({30'h0, pin_oe_out[0], pin_out[0]}, 32'h0);
      $display("pad test done");
      wr(`GPP_OFS_ODRAIN, 32'h0);
      wr(`GPP_OFS_DIR, 32'h0200);
      wr(`GPP_OFS_PSEL, 32'hA0);
      rnd = lfsr(rnd);
      @(posedge core_clk_in);
      periph_oe_in <= 8'hFF;
      periph_val_in <= rnd[7:0];
      settle(6);
      chk({16'h0, pin_oe_out, pin_out & 8'h30}, {16'h30, rnd[7:0] & 8'h30});
      chk({24'h0, periph_val_out}, {24'h0, rnd[7:0] & 8'h30});
      $display("peripheral test done");
      wr(`GPP_OFS_PSEL, 32'h0);
      wr(`GPP_OFS_DIR, 32'h0);
      @(posedge core_clk_in);
      periph_oe_in <= 8'h0;
      ext_en <= 8'h01;
      ext_val <= 8'h0;
      for (logic [2:0] k = 3'h0; k < 3'h6; k++) begin
         wr(`GPP_OFS_TRIG, {29'h0, k});
         wr(`GPP_OFS_IMASK, {31'h0, k[0]});
         settle(8);
         wr(`GPP_OFS_ICLR, 32'h1);
         settle(4);
         ext_val <= 8'h1;
         settle(8);
         rd(`GPP_OFS_RAW, {31'h0, ie[k][3]}, 32'h1);
         wr(`GPP_OFS_ICLR, 32'h1);
         settle(4);
         rd(`GPP_OFS_RAW, {31'h0, ie[k][2]}, 32'h1);
         ext_val <= 8'h0;
         settle(8);
         rd(`GPP_OFS_RAW, {31'h0, ie[k][1]}, 32'h1);
         wr(`GPP_OFS_ICLR, 32'h1);
         settle(4);
         rd(`GPP_OFS_RAW, {31'h0, ie[k][0]}, 32'h1);
         rd(`GPP_OFS_MASKED, {31'h0, ie[k][0] & k[0]}, 32'hFF);
         settle(1);
         chk({31'h0, irq_out}, {31'h0, ie[k][0] & k[0]});
      end
      $display("interrupt test done");
      settle(2);
      wrap_up();
   end
endmodule
